// File: rtl/dpt_timer_defs.vh
`ifndef DPT_TIMER_DEFS_VH
`define DPT_TIMER_DEFS_VH

// Word indices of the register words (address bits 5:2).
`define DPT_OFS_CTRL    4'h0
`define DPT_OFS_CNT0    4'h1
`define DPT_OFS_CNT1    4'h2
`define DPT_OFS_CNT2    4'h3
`define DPT_OFS_CNT3    4'h4
`define DPT_OFS_RLD0    4'h5
`define DPT_OFS_RLD1    4'h6
`define DPT_OFS_RLD0_HI 4'h7
`define DPT_OFS_RLD1_HI 4'h8
`define DPT_OFS_RLD2    4'h9
`define DPT_OFS_RLD3    4'ha
`define DPT_OFS_STAT    4'hb

// Control register fields.
`define DPT_CTL_EN0   0
`define DPT_CTL_EN1   1
`define DPT_CTL_EN_B  2
`define DPT_CTL_ARL0  3
`define DPT_CTL_ARL1  4
`define DPT_CTL_CASC  5
`define DPT_CTL_W     6
`define DPT_CTL_RST   6'h00

// Timing and counting constants.
`define DPT_PRE_W     3
`define DPT_PRE_LAST  3'h7
`define DPT_ONE8      8'h01
`define DPT_ONE16     16'h0001
`define DPT_ZERO8     8'h00
`define DPT_RLD_N     6

`endif

// File: rtl/dpt_timer.v
`timescale 1ns/1ns
`include "dpt_timer_defs.vh"

module dpt_timer
(
	input  wire        clock,       // Oscillator clock, 25 MHz.
	input  wire        rst_n,       // Asynchronous reset, active low.
	input  wire [5:0]  address,     // Avalon byte address.
	input  wire        read,        // Avalon read request.
	input  wire        write,       // Avalon write request.
	input  wire [31:0] writedata,   // Avalon write data.
	input  wire [3:0]  byteenable,  // Avalon byte enables.
	output reg  [31:0] readdata,    // Avalon read data.
	output wire        waitrequest, // Avalon wait request.
	input  wire [2:0]  out_sel,     // Pin set as timer output, per source.
	output reg         irq_a_low,   // Pair A low timer interrupt pulse.
	output reg         irq_a_high,  // Pair A high timer interrupt pulse.
	output reg         irq_b,       // Pair B interrupt pulse.
	output reg  [2:0]  tmr_out      // Toggling timer output levels.
);

	reg                  rs1_r;
	reg                  rst_sync_n;
	reg                  ack_r;
	reg [`DPT_PRE_W-1:0] pre_r;
	reg [`DPT_CTL_W-1:0] ctrl_r;
	reg [`DPT_CTL_W-1:0] ctrl_nxt;
	reg [7:0]            c0_r;
	reg [7:0]            c1_r;
	reg [7:0]            c2_r;
	reg [7:0]            c3_r;
	reg [7:0]            c0_nxt;
	reg [7:0]            c1_nxt;
	reg [7:0]            c2_nxt;
	reg [7:0]            c3_nxt;
	reg [31:0]           rdata_nxt;
	reg                  phase_r;
	reg                  phase_nxt;
	reg                  ia0_nxt;
	reg                  ia1_nxt;
	reg                  ib_nxt;
	reg [`DPT_CTL_W-1:0] hw_clr;

	wire        req_w;
	wire        wr_en;
	wire        rd_en;
	wire [3:0]  idx_w;
	wire        tick_w;
	wire        casc_w;
	wire [15:0] pa_w;
	wire [15:0] pb_w;
	wire [15:0] pa_dec;
	wire [15:0] pb_dec;
	wire [7:0]  c0_dec;
	wire [7:0]  c1_dec;
	wire [7:0]  wd_w;
	wire [7:0]  r0_r;
	wire [7:0]  r1_r;
	wire [7:0]  r0h_r;
	wire [7:0]  r1h_r;
	wire [7:0]  r2_r;
	wire [7:0]  r3_r;
	wire [2:0]  pin_nxt;
	wire [2:0]  evt_w;
	wire [7:0]  rld_w [0:`DPT_RLD_N-1];

	genvar      gi;

	// Reset release through two flip-flops.
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rs1_r      <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rs1_r      <= 1'b1;
			rst_sync_n <= rs1_r;
		end
	end

	// Each access waits one cycle so that read data comes from a flop.
	assign req_w       = read | write;
	assign waitrequest = req_w & ~ack_r;
	assign wr_en       = write & ack_r & byteenable[0];
	assign rd_en       = read & ~ack_r;
	assign idx_w       = address[5:2];
	assign wd_w        = writedata[7:0];

	assign tick_w = (pre_r == `DPT_PRE_LAST);
	assign casc_w = ctrl_r[`DPT_CTL_CASC];
	assign pa_w   = {c1_r, c0_r};
	assign pb_w   = {c3_r, c2_r};
	assign pa_dec = pa_w - `DPT_ONE16;
	assign pb_dec = pb_w - `DPT_ONE16;
	assign c0_dec = c0_r - `DPT_ONE8;
	assign c1_dec = c1_r - `DPT_ONE8;

	// Reload registers are written only by software, one per entry.
	// Their offsets follow one another, so each entry finds its own.
	generate
		for (gi = 0; gi < `DPT_RLD_N; gi = gi + 1)
		begin : g_rld
			localparam integer OFS = `DPT_OFS_RLD0 + gi;
			reg [7:0] val_r;
			always @(posedge clock or negedge rst_sync_n)
			begin
				if (!rst_sync_n)
					val_r <= `DPT_ZERO8;
				else if (wr_en && (idx_w == OFS[3:0]))
					val_r <= wd_w;
			end
			assign rld_w[gi] = val_r;
		end
	endgenerate

	assign r0_r  = rld_w[0];
	assign r1_r  = rld_w[1];
	assign r0h_r = rld_w[2];
	assign r1h_r = rld_w[3];
	assign r2_r  = rld_w[4];
	assign r3_r  = rld_w[5];

	// Each pin toggles on an expiry of its source when selected.
	assign evt_w = {ib_nxt, ia1_nxt, ia0_nxt};
	generate
		for (gi = 0; gi < 3; gi = gi + 1)
		begin : g_pin
			assign pin_nxt[gi] = tmr_out[gi] ^ (out_sel[gi] & evt_w[gi]);
		end
	endgenerate

	// Read data are selected here and captured in a flop below.
	always @*
	begin
		rdata_nxt = 32'h00000000;
		case (idx_w)
			`DPT_OFS_CTRL:    rdata_nxt = {26'h0, ctrl_r};
			`DPT_OFS_CNT0:    rdata_nxt = {24'h0, c0_r};
			`DPT_OFS_CNT1:    rdata_nxt = {24'h0, c1_r};
			`DPT_OFS_CNT2:    rdata_nxt = {24'h0, c2_r};
			`DPT_OFS_CNT3:    rdata_nxt = {24'h0, c3_r};
			`DPT_OFS_RLD0:    rdata_nxt = {24'h0, r0_r};
			`DPT_OFS_RLD1:    rdata_nxt = {24'h0, r1_r};
			`DPT_OFS_RLD0_HI: rdata_nxt = {24'h0, r0h_r};
			`DPT_OFS_RLD1_HI: rdata_nxt = {24'h0, r1h_r};
			`DPT_OFS_RLD2:    rdata_nxt = {24'h0, r2_r};
			`DPT_OFS_RLD3:    rdata_nxt = {24'h0, r3_r};
			`DPT_OFS_STAT:    rdata_nxt = {28'h0, tmr_out, phase_r};
			default:          rdata_nxt = 32'h00000000;
		endcase
	end

	always @*
	begin
		ctrl_nxt  = ctrl_r;
		c0_nxt    = c0_r;
		c1_nxt    = c1_r;
		c2_nxt    = c2_r;
		c3_nxt    = c3_r;
		phase_nxt = phase_r;
		ia0_nxt   = 1'b0;
		ia1_nxt   = 1'b0;
		ib_nxt    = 1'b0;
		hw_clr    = `DPT_CTL_RST;
		if (tick_w)
		begin
			if (casc_w)
			begin
				if (ctrl_r[`DPT_CTL_EN0])
				begin
					if (pa_w <= `DPT_ONE16)
					begin
						// Alternate reloads; PWM reloads always.
						if (!phase_r)
						begin
							ia1_nxt   = 1'b1;
							c0_nxt    = r0_r;
							c1_nxt    = r1_r;
							phase_nxt = 1'b1;
						end
						else
						begin
							ia0_nxt   = 1'b1;
							c0_nxt    = r0h_r;
							c1_nxt    = r1h_r;
							phase_nxt = 1'b0;
						end
					end
					else
					begin
						c0_nxt = pa_dec[7:0];
						c1_nxt = pa_dec[15:8];
					end
				end
			end
			else
			begin
				// Independent timers, each with its own reload.
				if (ctrl_r[`DPT_CTL_EN0])
				begin
					if (c0_r <= `DPT_ONE8)
					begin
						ia0_nxt = 1'b1;
						if (ctrl_r[`DPT_CTL_ARL0])
							c0_nxt = r0_r;
						else
						begin
							c0_nxt = `DPT_ZERO8;
							hw_clr[`DPT_CTL_EN0] = 1'b1;
						end
					end
					else
						c0_nxt = c0_dec;
				end
				if (ctrl_r[`DPT_CTL_EN1])
				begin
					if (c1_r <= `DPT_ONE8)
					begin
						ia1_nxt = 1'b1;
						if (ctrl_r[`DPT_CTL_ARL1])
							c1_nxt = r1_r;
						else
						begin
							c1_nxt = `DPT_ZERO8;
							hw_clr[`DPT_CTL_EN1] = 1'b1;
						end
					end
					else
						c1_nxt = c1_dec;
				end
			end
			// Pair B is always one free-running 16-bit timer.
			if (ctrl_r[`DPT_CTL_EN_B])
			begin
				if (pb_w <= `DPT_ONE16)
				begin
					ib_nxt = 1'b1;
					c2_nxt = r2_r;
					c3_nxt = r3_r;
				end
				else
				begin
					c2_nxt = pb_dec[7:0];
					c3_nxt = pb_dec[15:8];
				end
			end
		end
		// Software writes are applied after the writeback.
		if (wr_en)
		begin
			case (idx_w)
				`DPT_OFS_CTRL: ctrl_nxt = writedata[`DPT_CTL_W-1:0];
				`DPT_OFS_CNT0: c0_nxt = wd_w;
				`DPT_OFS_CNT1: c1_nxt = wd_w;
				`DPT_OFS_CNT2: c2_nxt = wd_w;
				`DPT_OFS_CNT3: c3_nxt = wd_w;
				default: ;
			endcase
		end
		ctrl_nxt = ctrl_nxt & ~hw_clr;
		// The PWM restarts with the low reload whenever it is stopped.
		if (!(casc_w & ctrl_r[`DPT_CTL_EN0]))
			phase_nxt = 1'b0;
	end

	always @(posedge clock or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			ack_r      <= 1'b0;
			pre_r      <= {`DPT_PRE_W{1'b0}};
			ctrl_r     <= `DPT_CTL_RST;
			c0_r       <= `DPT_ZERO8;
			c1_r       <= `DPT_ZERO8;
			c2_r       <= `DPT_ZERO8;
			c3_r       <= `DPT_ZERO8;
			phase_r    <= 1'b0;
			irq_a_low  <= 1'b0;
			irq_a_high <= 1'b0;
			irq_b      <= 1'b0;
			tmr_out    <= 3'h0;
			readdata   <= 32'h00000000;
		end
		else
		begin
			ack_r      <= req_w & ~ack_r;
			pre_r      <= pre_r + 3'h1;
			ctrl_r     <= ctrl_nxt;
			c0_r       <= c0_nxt;
			c1_r       <= c1_nxt;
			c2_r       <= c2_nxt;
			c3_r       <= c3_nxt;
			phase_r    <= phase_nxt;
			irq_a_low  <= ia0_nxt;
			irq_a_high <= ia1_nxt;
			irq_b      <= ib_nxt;
			// Output pins toggle on every expiry of their source when selected by out_sel.
			tmr_out    <= pin_nxt;
			// Reads have no side effect on the timers.
			if (rd_en)
				readdata <= rdata_nxt;
		end
	end

endmodule

// File: verification/dpt_timer_asserts.sv
`timescale 1ns/1ns
module dpt_timer_asserts
(
	input wire        clock,       // Clock.
	input wire        rst_n,       // Reset.
	input wire [5:0]  address,     // Address.
	input wire        read,        // Read.
	input wire        write,       // Write.
	input wire [31:0] readdata,    // Read data.
	input wire        waitrequest, // Wait.
	input wire [2:0]  out_sel,     // Pin select.
	input wire        irq_a_low,   // Irq.
	input wire        irq_a_high,  // Irq.
	input wire        irq_b,       // Irq.
	input wire [2:0]  tmr_out      // Pins.
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence s_quiet(sig);
		!sig [*7];
	endsequence
	irq_lo_gap_a:
	assert property (irq_a_low |=> s_quiet(irq_a_low)) else $error("Low gap.");
	irq_hi_gap_a:
	assert property (irq_a_high |=> s_quiet(irq_a_high)) else $error("High gap.");
	irq_b_gap_a:
	assert property (irq_b |=> s_quiet(irq_b)) else $error("Pair B gap.");
	wait_first_a:
	assert property ($rose(read || write) |-> waitrequest)
		else $error("No wait in first cycle.");
	wait_one_a:
	assert property (waitrequest |=> !waitrequest) else $error("Wait too long.");
	rd_byte_a:
	assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
		else $error("Upper read bits set.");
	rd_unmap_a:
	assert property (read && !waitrequest && address[5:2] > 4'hb
		|-> readdata == 32'h0) else $error("Unmapped read not zero.");
	out_gate_a:
	assert property (out_sel[2:1] == 2'h0 && $past(out_sel[2:1]) == 2'h0
		|-> $stable(tmr_out[2:1])) else $error("Ungated pin toggled.");
endmodule
bind dpt_timer dpt_timer_asserts dpt_timer_asserts_i (.clock(clock),
	.rst_n(rst_n), .address(address), .read(read), .write(write),
	.readdata(readdata), .waitrequest(waitrequest), .out_sel(out_sel),
	.irq_a_low(irq_a_low), .irq_a_high(irq_a_high), .irq_b(irq_b),
	.tmr_out(tmr_out));

// File: verification/dpt_timer_test.sv
`timescale 1ns/1ns
module dpt_timer_test;
	reg         clock;
	reg         rst_n;
	reg  [5:0]  address;
	reg         read;
	reg         write;
	reg  [31:0] writedata;
	wire [31:0] readdata;
	wire        waitrequest;
	wire        irq_a_low;
	wire        irq_a_high;
	wire        irq_b;
	wire [2:0]  tmr_out;
	reg  [7:0]  rd;
	reg  [2:0]  out_sel;
	reg  [2:0]  seen;
	integer     cyc;
	integer     fail_count;
	integer     total_checks;
	dpt_timer dpt_timer_i (.clock(clock), .rst_n(rst_n), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
		.out_sel(out_sel), .irq_a_low(irq_a_low), .irq_a_high(irq_a_high),
		.irq_b(irq_b), .tmr_out(tmr_out));
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	task check(input [31:0] got, input [31:0] exp);
	begin
		total_checks = total_checks + 1;
		if (got !== exp)
		begin
			fail_count = fail_count + 1;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	end
	endtask
	// The request is held until waitrequest is seen low at an edge.
	task bus(input wr, input [3:0] w, input [7:0] d);
		integer n;
	begin
		@(posedge clock);
		address <= {w, 2'b00};
		writedata <= {24'h0, d};
		write <= wr;
		read <= ~wr;
		n = 0;
		@(posedge clock);
		while (waitrequest !== 1'b0 && n < 20)
		begin
			@(posedge clock);
			n = n + 1;
		end
		if (n == 20)
			fail_count = fail_count + 1;
		rd = readdata[7:0];
		write <= 1'b0;
		read <= 1'b0;
	end
	endtask
	task wait_irq;
	begin
		cyc = 0;
		seen = 3'h0;
		while (seen == 3'h0 && cyc < 2200)
		begin
			@(posedge clock);
			cyc = cyc + 1;
			seen = {irq_b, irq_a_high, irq_a_low};
		end
	end
	endtask
	task test_done;
	begin
		$display("checks %0d fails %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask
	initial
	begin
		#240000;
		fail_count = fail_count + 1;
		test_done;
	end
	initial
	begin
		rst_n = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 6'h00;
		writedata = 32'h0;
		out_sel = 3'h1;
		fail_count = 0;
		total_checks = 0;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		bus(0, 4'h0, 8'h00);
		check(rd, 8'h00);
		bus(1, 4'h5, 8'ha5);
		bus(0, 4'h5, 8'h00);
		check(rd, 8'ha5);
		bus(0, 4'hf, 8'h00);
		check(rd, 8'h00);
		bus(1, 4'h1, 8'h02);
		bus(1, 4'h2, 8'h04);
		bus(1, 4'h0, 8'h03);
		wait_irq;
		check(seen, 3'h1);
		wait_irq;
		check(seen, 3'h2);
		check(cyc, 16);
		bus(0, 4'h0, 8'h00);
		check(rd, 8'h00);
		bus(0, 4'hb, 8'h00);
		check(rd & 8'h0e, 8'h02);
		bus(1, 4'h9, 8'h03);
		bus(1, 4'ha, 8'h00);
		bus(1, 4'h3, 8'h00);
		bus(1, 4'h4, 8'h01);
		bus(1, 4'h0, 8'h04);
		wait_irq;
		check(seen, 3'h4);
		bus(0, 4'h3, 8'h00);
		check(rd, 8'h03);
		bus(0, 4'h4, 8'h00);
		check(rd, 8'h00);
		wait_irq;
		wait_irq;
		check(cyc, 24);
		bus(1, 4'h0, 8'h00);
		out_sel <= 3'h3;
		bus(1, 4'h5, 8'h02);
		bus(1, 4'h6, 8'h00);
		bus(1, 4'h7, 8'h03);
		bus(1, 4'h8, 8'h00);
		bus(1, 4'h1, 8'h03);
		bus(1, 4'h2, 8'h00);
		bus(1, 4'h0, 8'h21);
		wait_irq;
		check(seen, 3'h2);
		check(tmr_out, 3'h3);
		wait_irq;
		check(seen, 3'h1);
		check(cyc, 16);
		wait_irq;
		check(seen, 3'h2);
		check(cyc, 24);
		test_done;
	end
endmodule
